/* logic/axil_slave_port.sv */
// AXI4-Lite slave front end: one write and one read in flight, fixed latency.
// Assumes the bank answers a write or read request combinationally in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "periph_off_regs.svh"
module axil_slave_port (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic [11:0]             awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [11:0]             araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   output periph_off_pkg::wr_req_s      wrReq,
   input  wire logic [1:0]              wrResp,
   output logic [11:0]                  rdAddr,
   input  wire logic [31:0]             rdData,
   input  wire logic [1:0]              rdResp
);
   logic        awHeld, wHeld, arHeld, rdFire;
   logic [11:0] wrAddr_reg;
   logic [31:0] wrData_reg;
   logic [3:0]  wrStrb_reg;

   assign awready = !awHeld && !bvalid;
   assign wready = !wHeld && !bvalid;
   assign arready = !arHeld && !rvalid;
   // One driver for the whole bundle; the held fields are registered below
   assign wrReq = '{valid: awHeld && wHeld && !bvalid,
                    addr:  wrAddr_reg,
                    data:  wrData_reg,
                    strb:  wrStrb_reg};
   assign rdFire = arHeld && !rvalid;

   always_ff @(posedge clk) begin
      if (srst || wrReq.valid) awHeld <= 1'b0;
      else if (awvalid && awready) awHeld <= 1'b1;
      if (srst || wrReq.valid) wHeld <= 1'b0;
      else if (wvalid && wready) wHeld <= 1'b1;
   end

   always_ff @(posedge clk) begin
      if (awvalid && awready) wrAddr_reg <= awaddr;
      if (wvalid && wready) begin
         wrData_reg <= wdata;
         wrStrb_reg <= wstrb;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bvalid <= 1'b0;
         bresp  <= `POFF_RESP_OKAY;
      end else if (wrReq.valid) begin
         bvalid <= 1'b1;
         bresp  <= wrResp;
      end else if (bready) bvalid <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         arHeld <= 1'b0;
         rdAddr <= 12'h000;
      end else if (arvalid && arready) begin
         arHeld <= 1'b1;
         rdAddr <= araddr;
      end else if (rdFire) arHeld <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `POFF_RESP_OKAY;
      end else if (rdFire) begin
         rvalid <= 1'b1;
         rdata  <= rdData;
         rresp  <= rdResp;
      end else if (rready) rvalid <= 1'b0;
   end
endmodule // axil_slave_port
`default_nettype wire

/* logic/periph_disable_bank.sv */
// Peripheral disable bank: seven control bytes on AXI4-Lite, one bit per peripheral.
// Assumes peripherals take holdReset as a synchronous reset and route their
// register accesses through the sfr port below.
`timescale 1ns/1ps
`default_nettype none
`include "periph_off_regs.svh"
module periph_disable_bank (
   input  wire logic                  clk,
   input  wire logic                  srst,
   // AXI4-Lite register port
   input  wire logic [11:0]           awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [11:0]           araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // Fuse levels: high keeps that zero-cross detector running
   input  wire logic                  zeroCross1FuseOn,
   input  wire logic                  zeroCross2FuseOn,
   // Register contents and per-peripheral controls
   output periph_off_pkg::bank_s      offState,
   output periph_off_pkg::bank_s      holdReset,
   output periph_off_pkg::bank_s      sfrBlocked,
   // Peripheral register access path, peripheral selected by flat bit index
   input  wire logic [5:0]            sfrSel,
   input  wire logic                  sfrWrEn,
   input  wire logic                  sfrRdEn,
   input  wire logic [7:0]            sfrRdDataIn,
   output logic                       sfrWrEnOut,
   output logic [7:0]                 sfrRdDataOut
);
   localparam int NumRegs = 7;

   periph_off_pkg::wr_req_s    wrReq;
   logic [1:0]                 wrResp;
   logic [11:0]                rdAddr;
   logic [31:0]                rdData;
   logic [1:0]                 rdResp;

   periph_off_pkg::ctrl_byte_t ctrlReg [NumRegs];
   logic [NumRegs-1:0]         wrHit;
   logic                       wrHitAny;
   logic                       wrHitRecover;
   logic                       wrHitEarly;
   logic [55:0]                offFlat;
   logic [55:0]                forceOnFlat;
   logic [55:0]                holdFlat;
   logic [55:0]                blockFlat;
   logic [55:0]                recoverFlat;
   logic [NumRegs-1:0]         recoverByReg;
   logic [NumRegs-1:0]         early_reg;
   logic [NumRegs-1:0]         early_next;
   logic [NumRegs-1:0]         earlySet;
   logic                       selValid;
   logic                       selBlocked;
   logic                       selRecovering;

   // Register index of bank position n
   function automatic logic [7:0] regIdx(input int unsigned n);
      case (n)
         0:       return `POFF_IDX_CTRL0;
         1:       return `POFF_IDX_CTRL1;
         2:       return `POFF_IDX_CTRL2;
         3:       return `POFF_IDX_CTRL3;
         4:       return `POFF_IDX_CTRL4;
         5:       return `POFF_IDX_CTRL5;
         default: return `POFF_IDX_CTRL6;
      endcase
   endfunction

   // Implemented bits of bank position n
   function automatic logic [7:0] regMask(input int unsigned n);
      case (n)
         0:       return `POFF_MASK_CTRL0;
         6:       return `POFF_MASK_CTRL6;
         default: return `POFF_MASK_FULL;
      endcase
   endfunction

   // Word-aligned decode; low two address bits are ignored as AXI allows
   function automatic logic hits(input logic [11:0] addr, input logic [7:0] idx);
      return addr[11:2] == {2'b00, idx};
   endfunction

   axil_slave_port u_bus (
      .clk     (clk),
      .srst    (srst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wrReq   (wrReq),
      .wrResp  (wrResp),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdResp  (rdResp)
   );

   // Control bytes; only byte lane 0 carries register data
   for (genvar g = 0; g < NumRegs; g++) begin : gRegs
      assign wrHit[g] = wrReq.valid && hits(wrReq.addr, regIdx(g));

      always_ff @(posedge clk) begin
         if (srst) ctrlReg[g] <= `POFF_RESET;
         else if (wrHit[g] && wrReq.strb[0])
            ctrlReg[g] <= wrReq.data[7:0] & regMask(g);
      end

      assign offFlat[g*8 +: 8] = ctrlReg[g];
      assign recoverByReg[g] = |recoverFlat[g*8 +: 8];
   end

   assign wrHitRecover = wrReq.valid && hits(wrReq.addr, `POFF_IDX_RECOVER);
   assign wrHitEarly = wrReq.valid && hits(wrReq.addr, `POFF_IDX_EARLY);
   assign wrHitAny = (|wrHit) || wrHitRecover || wrHitEarly;
   assign wrResp = wrHitAny ? `POFF_RESP_OKAY : `POFF_RESP_SLVERR;

   // Field view of the bank; positions follow the packed layouts
   assign offState = periph_off_pkg::bank_s'(offFlat);
   // Same view carries the remaining registers' maps

   // Only the two zero-cross detectors have a fuse above their disable bit
   always_comb begin
      forceOnFlat = 56'h00_0000_0000_0000;
      forceOnFlat[`POFF_ZC1_POS] = zeroCross1FuseOn;
      forceOnFlat[`POFF_ZC2_POS] = zeroCross2FuseOn;
   end

   for (genvar p = 0; p < 56; p++) begin : gGates
      periph_recover_gate u_gate (
         .clk        (clk),
         .srst       (srst),
         .offReq     (offFlat[p]),
         .forceOn    (forceOnFlat[p]),
         .holdReset  (holdFlat[p]),
         .sfrBlock   (blockFlat[p]),
         .recovering (recoverFlat[p])
      );
   end

   assign holdReset = periph_off_pkg::bank_s'(holdFlat);
   assign sfrBlocked = periph_off_pkg::bank_s'(blockFlat);

   // Peripheral register path: writes are dropped and reads return zero while blocked
   assign selValid = {1'b0, sfrSel} < `POFF_NUM_PERIPH;
   assign selBlocked = selValid && blockFlat[sfrSel];
   assign selRecovering = selValid && recoverFlat[sfrSel];
   assign sfrWrEnOut = sfrWrEn && !selBlocked;

   always_ff @(posedge clk) begin
      if (srst) sfrRdDataOut <= 8'h00;
      else if (sfrRdEn) sfrRdDataOut <= selBlocked ? 8'h00 : sfrRdDataIn;
   end

   // Accesses inside the guard window break software's side of the re-enable
   // contract; they are recorded per register so firmware can find the culprit
   always_comb begin
      earlySet = '0;
      if ((sfrWrEn || sfrRdEn) && selRecovering) earlySet[sfrSel[5:3]] = 1'b1;
   end

   // Write one to clear; a new event in the same cycle wins over the clear
   always_comb begin
      early_next = early_reg;
      if (wrHitEarly && wrReq.strb[0]) early_next = early_reg & ~wrReq.data[NumRegs-1:0];
      early_next = early_next | earlySet;
   end

   always_ff @(posedge clk) begin
      if (srst) early_reg <= '0;
      else early_reg <= early_next;
   end

   // Read mux; the front end registers the result
   always_comb begin
      rdData = 32'h0000_0000;
      rdResp = `POFF_RESP_SLVERR;
      for (int i = 0; i < NumRegs; i++) begin
         if (hits(rdAddr, regIdx(i))) begin
            rdData = {24'h00_0000, ctrlReg[i]};
            rdResp = `POFF_RESP_OKAY;
         end
      end
      if (hits(rdAddr, `POFF_IDX_RECOVER)) begin
         rdData = {25'h000_0000, recoverByReg};
         rdResp = `POFF_RESP_OKAY;
      end
      if (hits(rdAddr, `POFF_IDX_EARLY)) begin
         rdData = {25'h000_0000, early_reg};
         rdResp = `POFF_RESP_OKAY;
      end
   end
endmodule // periph_disable_bank
`default_nettype wire

/* logic/periph_off_pkg.sv */
// Types of the peripheral disable bank: per-register field layouts and bus bundles.
// Assumes nothing beyond the constants header.
`default_nettype none
package periph_off_pkg;
   typedef logic [7:0] ctrl_byte_t;

   typedef struct packed {
      logic sysclk_net_off;
      logic volt_ref_off;
      logic volt_detect_off;
      logic crc_off;
      logic mem_scan_off;
      logic unused;
      logic clk_ref_out_off;
      logic pin_change_off;
   } ctrl0_s;
   typedef struct packed {
      logic       comparator1_off;
      logic       zero_cross1_off;
      logic [5:0] timer_n_off;
   } ctrl1_s;
   typedef struct packed {
      logic capture_compare2_off;
      logic capture_compare1_off;
      logic compl_waveform_off;
      logic num_ctrl_osc_off;
      logic clock_tuning_off;
      logic dac_off;
      logic adc_off;
      logic comparator2_off;
   } ctrl2_s;
   typedef struct packed {
      logic [1:0] uart_n_off;
      logic       spi2_off;
      logic       spi1_off;
      logic       i2c1_off;
      logic [2:0] pwm_n_off;
   } ctrl3_s;
   typedef struct packed {
      logic [2:0] dma_n_off;
      logic [3:0] logic_cell_n_off;
      logic       i2c2_off;
   } ctrl4_s;
   typedef struct packed {
      logic [3:0] logic_cell_hi_off;
      logic       dma4_off;
      logic       universal_timer_b_off;
      logic       universal_timer_a_off;
      logic       zero_cross2_off;
   } ctrl5_s;
   typedef struct packed {
      logic [6:0] unused;
      logic       signal_route_off;
   } ctrl6_s;
   typedef struct packed {
      ctrl6_s r6;
      ctrl5_s r5;
      ctrl4_s r4;
      ctrl3_s r3;
      ctrl2_s r2;
      ctrl1_s r1;
      ctrl0_s r0;
   } bank_s;

   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } wr_req_s;
endpackage
`default_nettype wire

/* logic/periph_off_regs.svh */
// Offsets, masks, reset values and timing counts of the peripheral disable bank.
// Assumes a 32-bit register bus where byte address = register index * 4.
`ifndef PERIPH_OFF_REGS_SVH
`define PERIPH_OFF_REGS_SVH

// Register indices; byte address is four times the index
`define POFF_IDX_CTRL0    8'h62
`define POFF_IDX_CTRL1    8'h63
`define POFF_IDX_CTRL2    8'h64
`define POFF_IDX_CTRL3    8'h65
`define POFF_IDX_CTRL4    8'h66
`define POFF_IDX_CTRL5    8'h67
`define POFF_IDX_CTRL6    8'h68
`define POFF_IDX_RECOVER  8'h69
`define POFF_IDX_EARLY    8'h6A

// Implemented-bit masks and reset value
`define POFF_MASK_CTRL0   8'hFB
`define POFF_MASK_FULL    8'hFF
`define POFF_MASK_CTRL6   8'h01
`define POFF_RESET        8'h00

// Flat bit positions of the fuse-governed zero-cross detectors, and the number of peripherals in the bank
`define POFF_ZC1_POS      6'h0E
`define POFF_ZC2_POS      6'h28
`define POFF_NUM_PERIPH   7'h38

// Bus answers
`define POFF_RESP_OKAY    2'h0
`define POFF_RESP_SLVERR  2'h2

// Timing: clock period, instruction cycle, re-enable guard of two instruction cycles
`define POFF_CLK_NS       20
`define POFF_INSTR_NS     80
`define POFF_RECOVER_NS   (2 * `POFF_INSTR_NS)
`define POFF_RECOVER_CYC  ((`POFF_RECOVER_NS + `POFF_CLK_NS - 1) / `POFF_CLK_NS)

`endif

/* logic/periph_recover_gate.sv */
// Per-peripheral gate: reset hold while disabled, register block through re-enable guard.
// Assumes one clock; the guard count comes from the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "periph_off_regs.svh"
module periph_recover_gate (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic offReq,
   input  wire logic forceOn,
   output logic      holdReset,
   output logic      sfrBlock,
   output logic      recovering
);
   logic [3:0] guard_reg;
   logic       effOff;

   assign effOff = offReq && !forceOn;
   assign holdReset = effOff;

   // Guard reloads while off so the full window runs from the clearing edge
   always_ff @(posedge clk) begin
      if (srst) guard_reg <= 4'h0;
      else if (effOff) guard_reg <= 4'(`POFF_RECOVER_CYC);
      else if (guard_reg != 4'h0) guard_reg <= guard_reg - 4'h1;
   end

   // The counter sits loaded while off; only the run after re-enable is recovery
   assign recovering = !effOff && (guard_reg != 4'h0);
   assign sfrBlock = effOff || recovering;
endmodule // periph_recover_gate
`default_nettype wire

/* verif/periph_disable_bank_sva.sv */
// Assertion checker of the peripheral disable bank.
// Assumes it is bound to periph_disable_bank and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module periph_disable_bank_chk (
   input wire logic                  clk,
   input wire logic                  srst,
   input wire logic [11:0]           awaddr,
   input wire logic                  awvalid,
   input wire logic                  awready,
   input wire logic [31:0]           wdata,
   input wire logic [3:0]            wstrb,
   input wire logic                  wvalid,
   input wire logic                  wready,
   input wire logic                  bvalid,
   input wire logic [11:0]           araddr,
   input wire logic                  arvalid,
   input wire logic                  arready,
   input wire logic [31:0]           rdata,
   input wire logic                  rvalid,
   input wire logic                  zeroCross1FuseOn,
   input wire logic                  zeroCross2FuseOn,
   input wire periph_off_pkg::bank_s offState,
   input wire periph_off_pkg::bank_s holdReset,
   input wire periph_off_pkg::bank_s sfrBlocked,
   input wire logic [5:0]            sfrSel,
   input wire logic                  sfrWrEn,
   input wire logic                  sfrRdEn,
   input wire logic [7:0]            sfrRdDataIn,
   input wire logic                  sfrWrEnOut,
   input wire logic [7:0]            sfrRdDataOut
);
   logic        blk;
   logic [55:0] fuseMask;
   // Indices past the last bank bit are never blocked
   assign blk = (sfrSel < 6'h38) && sfrBlocked[sfrSel];
   assign fuseMask = (56'(zeroCross1FuseOn) << 14) | (56'(zeroCross2FuseOn) << 40);

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence wrTaken;
      awvalid && awready && wvalid && wready;
   endsequence
   // Guard after re-enable spans two instruction cycles of four clocks
   sequence guardRun;
      sfrBlocked[8] [*8] ##1 !sfrBlocked[8];
   endsequence

   AST_HOLD_MAP: assert property (holdReset == (offState & ~fuseMask))
      else $error("hold reset does not follow bits and fuses");
   AST_UNIMPL: assert property (offState[2] == 1'h0 && offState[55:49] == 7'h00)
      else $error("unimplemented bit reads nonzero");
   AST_RESET: assert property ($fell(srst) |-> offState == 56'h0 && !bvalid && !rvalid)
      else $error("state not cleared by reset");
   AST_BLOCK_COVER: assert property ((holdReset & ~sfrBlocked) == 56'h0)
      else $error("held peripheral not blocked");
   AST_GUARD: assert property ((!$past(srst) && $fell(holdReset[8])) |-> guardRun)
      else $error("re-enable guard length wrong");
   AST_WR_GATE: assert property (sfrWrEnOut == (sfrWrEn && !blk))
      else $error("peripheral write gating wrong");
   AST_RD_ZERO: assert property (sfrRdEn |=>
      sfrRdDataOut == ($past(blk) ? 8'h00 : $past(sfrRdDataIn)))
      else $error("peripheral read data wrong");
   AST_WR_CTRL2: assert property (wrTaken ##0 (awaddr == 12'h190 && wstrb[0]) |->
      ##2 (bvalid && offState[23:16] == $past(wdata[7:0], 2)))
      else $error("third register write not applied");
   AST_RD_CTRL3: assert property ((arvalid && arready && araddr == 12'h194) |->
      ##2 (rvalid && rdata == {24'h0, offState[31:24]}))
      else $error("fourth register read wrong");
endmodule // periph_disable_bank_chk

bind periph_disable_bank periph_disable_bank_chk i_periph_disable_bank_chk (
   .clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
   .bvalid, .araddr, .arvalid, .arready, .rdata, .rvalid, .zeroCross1FuseOn,
   .zeroCross2FuseOn, .offState, .holdReset, .sfrBlocked, .sfrSel, .sfrWrEn,
   .sfrRdEn, .sfrRdDataIn, .sfrWrEnOut, .sfrRdDataOut);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench of the peripheral disable bank over AXI4-Lite.
// Assumes header, package and design compiled first; checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
`include "periph_off_regs.svh"
module tb;
   logic                  clk = 1'h0;
   logic                  srst = 1'h1;
   logic [11:0]           awaddr = 12'h000;
   logic [11:0]           araddr = 12'h000;
   logic [31:0]           wdata = 32'h0000_0000;
   logic [31:0]           rdata;
   logic [3:0]            wstrb = 4'h0;
   logic                  awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic                  arvalid = 1'h0, rready = 1'h0;
   logic                  awready, wready, bvalid, arready, rvalid, sfrWrEnOut;
   logic [1:0]            bresp, rresp;
   logic                  zeroCross1FuseOn = 1'h0, zeroCross2FuseOn = 1'h0;
   logic [5:0]            sfrSel = 6'h00;
   logic                  sfrWrEn = 1'h0, sfrRdEn = 1'h0;
   logic [7:0]            sfrRdDataIn = 8'h00, sfrRdDataOut, v;
   periph_off_pkg::bank_s offState, holdReset, sfrBlocked;
   logic [55:0]           eb;
   logic [31:0]           rv, u;
   logic [11:0]           bad [3] = '{12'h000, 12'h184, 12'h1ac};
   int                    fails = 0, samples_checked = 0, cyc = 0, n;

   periph_disable_bank i_periph_disable_bank (
      .clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .zeroCross1FuseOn, .zeroCross2FuseOn, .offState,
      .holdReset, .sfrBlocked, .sfrSel, .sfrWrEn, .sfrRdEn, .sfrRdDataIn,
      .sfrWrEnOut, .sfrRdDataOut);

   always #10 clk = ~clk;

   task end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails++;
         end_of_test();
      end
   end

   task chk(input string nm, input logic [55:0] e, input logic [55:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   function logic [11:0] ra(input int i);
      ra = 12'((`POFF_IDX_CTRL0 + i) * 4);
   endfunction

   function logic [7:0] msk(input int i);
      msk = (i == 0) ? 8'hfb : (i == 6) ? 8'h01 : 8'hff;
   endfunction

   // A blown fuse keeps its detector running whatever the bit says
   function logic [55:0] hexp(input logic [55:0] o, input logic f1, input logic f2);
      hexp = o;
      if (f1) hexp[14] = 1'h0;
      if (f2) hexp[40] = 1'h0;
   endfunction

   // Upper data bits are random: the bank must ignore them
   task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
      logic [31:0] r;
      int k;
      r = $urandom;
      @(posedge clk);
      awaddr <= a;
      wdata <= {r[31:8], d};
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid && k < 40);
      bready <= 1'h0;
      chk("bresp", er, bresp);
   endtask

   task rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
      int k;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (arready) arvalid <= 1'h0;
      end while (!rvalid && k < 40);
      d = rdata;
      rready <= 1'h0;
      chk("rresp", er, rresp);
   endtask

   task sfr(input logic [5:0] s, input logic [7:0] d, input logic ew, input logic [7:0] er);
      @(posedge clk);
      sfrSel <= s;
      sfrWrEn <= 1'h1;
      sfrRdEn <= 1'h1;
      sfrRdDataIn <= d;
      @(negedge clk);
      chk("sfrWrEnOut", ew, sfrWrEnOut);
      @(posedge clk);
      sfrWrEn <= 1'h0;
      sfrRdEn <= 1'h0;
      @(negedge clk);
      chk("sfrRdDataOut", er, sfrRdDataOut);
   endtask

   initial begin
      void'($urandom(32'h293b));
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      for (int i = 0; i < 7; i++) begin
         rd(ra(i), `POFF_RESP_OKAY, rv);
         chk("reset value", 56'h0, rv);
      end
      $display("test reset values done");
      eb = 56'h0;
      for (int i = 0; i < 7; i++) begin
         for (int j = 0; j < 9; j++) begin
            u = $urandom;
            v = (j < 8) ? (8'h01 << j) : u[7:0];
            zeroCross1FuseOn <= u[8];
            zeroCross2FuseOn <= u[9];
            wr(ra(i), v, 4'hf, `POFF_RESP_OKAY);
            eb[i*8 +: 8] = v & msk(i);
            rd(ra(i), `POFF_RESP_OKAY, rv);
            chk("read back", {24'h0, eb[i*8 +: 8]}, rv);
            chk("offState", eb, offState);
            chk("holdReset", hexp(eb, u[8], u[9]), holdReset);
         end
      end
      $display("test register map done");
      zeroCross1FuseOn <= 1'h1;
      zeroCross2FuseOn <= 1'h1;
      wr(ra(1), 8'hff, 4'hf, `POFF_RESP_OKAY);
      wr(ra(5), 8'hff, 4'hf, `POFF_RESP_OKAY);
      eb[15:8] = 8'hff;
      eb[47:40] = 8'hff;
      chk("fuse hold", hexp(eb, 1'h1, 1'h1), holdReset);
      chk("fuse bits", eb, offState);
      zeroCross1FuseOn <= 1'h0;
      @(posedge clk);
      chk("fuse release", hexp(eb, 1'h0, 1'h1), holdReset);
      $display("test fuses done");
      wr(ra(2), 8'h5a, 4'he, `POFF_RESP_OKAY);
      rd(ra(2), `POFF_RESP_OKAY, rv);
      chk("strobe off", {24'h0, eb[23:16]}, rv);
      foreach (bad[k]) begin
         wr(bad[k], 8'hff, 4'hf, `POFF_RESP_SLVERR);
         rd(bad[k], `POFF_RESP_SLVERR, rv);
         chk("unmapped read", 56'h0, rv);
      end
      chk("no side effect", eb, offState);
      $display("test refusals done");
      srst <= 1'h1;
      repeat (3) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      chk("reset offState", 56'h0, offState);
      chk("reset holdReset", 56'h0, holdReset);
      $display("test mid-run reset done");
      wr(ra(1), 8'h01, 4'hf, `POFF_RESP_OKAY);
      sfr(6'h08, 8'ha5, 1'h0, 8'h00);
      sfr(6'h09, 8'h3c, 1'h1, 8'h3c);
      rd(12'(`POFF_IDX_RECOVER * 4), `POFF_RESP_OKAY, rv);
      chk("recover while off", 56'h0, rv);
      wr(ra(1), 8'h00, 4'hf, `POFF_RESP_OKAY);
      chk("reenable", 56'h0, holdReset);
      sfr(6'h08, 8'h5a, 1'h0, 8'h00);
      n = 0;
      while (sfrBlocked[8] && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("guard length", 1, n >= 5 && n <= 7);
      sfr(6'h08, 8'h5a, 1'h1, 8'h5a);
      rd(12'(`POFF_IDX_RECOVER * 4), `POFF_RESP_OKAY, rv);
      chk("recover idle", 56'h0, rv);
      // Only the access inside the guard window of register 1 may be recorded
      rd(12'(`POFF_IDX_EARLY * 4), `POFF_RESP_OKAY, rv);
      chk("early flags", 56'h2, rv);
      wr(12'(`POFF_IDX_EARLY * 4), 8'h02, 4'hf, `POFF_RESP_OKAY);
      rd(12'(`POFF_IDX_EARLY * 4), `POFF_RESP_OKAY, rv);
      chk("early cleared", 56'h0, rv);
      $display("test peripheral access done");
      end_of_test();
   end
endmodule // tb
`default_nettype wire
